// File: rtl/pc_peak_monitor.sv
// Instruction counter with frame and all-time peak records behind APB
//
// Design decision made here: the APB interface to the registers.
`default_nettype none
module pc_peak_monitor
(
    // APB clock and reset
    input  wire logic        pclk,
    input  wire logic        presetn,
    // APB slave
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [31:0] paddr,
    input  wire logic [31:0] pwdata,
    input  wire logic [3:0]  pstrb,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    // Sequencer side
    input  wire logic        instr_step,
    input  wire logic        frame_start,
    // Status
    output logic      [23:0] live_count
);
    logic [15:0] clear_ctrl;
    logic [23:0] running_peak;
    logic [23:0] frame_peak;
    logic [23:0] alltime_peak;
    pc_peak_pkg::clear_state_t clear_state;
    pc_peak_pkg::clear_state_t next_clear_state;
    logic [31:0] rd_data;
    logic        rd_hit;
    logic        rd_pending;

    // Bus decode
    wire         setup_phase  = psel && !penable;
    wire         access_phase = psel && penable;
    wire         aligned      = (paddr[1:0] == 2'b00) && (paddr[31:18] == 14'h0000);
    wire [15:0]  reg_idx      = paddr[17:2];
    wire         rd_load      = setup_phase && !pwrite && aligned;
    wire         wr_clear     = access_phase && pwrite && aligned
                                && (reg_idx == pc_peak_pkg::IDX_CLEAR_CTRL);
    wire         clear_on     = clear_ctrl[pc_peak_pkg::CLEAR_BIT];
    wire         clear_fall   = (clear_state == pc_peak_pkg::CLEARING) && !clear_on;
    wire         known_idx    = aligned && (reg_idx >= pc_peak_pkg::IDX_LIVE_UPPER)
                                && (reg_idx <= pc_peak_pkg::IDX_ALLTIME_LOWER);
    wire         ro_write     = pwrite && (reg_idx != pc_peak_pkg::IDX_CLEAR_CTRL);
    wire [23:0]  next_count   = live_count + 24'h000001;
    wire [23:0]  next_peak    = (live_count > running_peak) ? live_count : running_peak;

    // Reads take no wait state: setup loads the read register
    assign pready  = access_phase && (pwrite || rd_pending);
    assign pslverr = access_phase && pready && (!known_idx || ro_write);
    assign prdata  = (access_phase && !pwrite && rd_hit && aligned) ? rd_data : 32'h00000000;

    // Read register bank
    pc_peak_regs u_regs
    (
        .pclk         (pclk),
        .presetn      (presetn),
        .rd_en        (rd_load),
        .rd_idx       (reg_idx),
        .live_count   (live_count),
        .frame_peak   (frame_peak),
        .alltime_peak (alltime_peak),
        .clear_ctrl   (clear_ctrl),
        .rd_data      (rd_data),
        .rd_hit       (rd_hit)
    );

    // Read wait state tracking
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            rd_pending <= 1'b0;
        else
            rd_pending <= setup_phase && !pwrite;
    end

    // Clear control register, each byte lane under its own strobe
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            clear_ctrl <= pc_peak_pkg::CLEAR_CTRL_RESET;
        else if (wr_clear)
            clear_ctrl <= {(pstrb[1] ? pwdata[15:8] : clear_ctrl[15:8]),
                           (pstrb[0] ? pwdata[7:0] : clear_ctrl[7:0])};
    end

    // Clear sequence tracker, leaving CLEARING marks the release of the bit
    always_comb
    begin
        next_clear_state = clear_state;
        case (clear_state)
            pc_peak_pkg::TRACK:
                if (clear_on)
                    next_clear_state = pc_peak_pkg::CLEARING;
            pc_peak_pkg::CLEARING:
                if (!clear_on)
                    next_clear_state = pc_peak_pkg::TRACK;
            default:
                next_clear_state = pc_peak_pkg::TRACK;
        endcase
    end

    // Clear sequence state register
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            clear_state <= pc_peak_pkg::TRACK;
        else
            clear_state <= next_clear_state;
    end

    // Live counter
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            live_count <= pc_peak_pkg::PEAK_RESET;
        else if (clear_on)
            live_count <= pc_peak_pkg::PEAK_RESET;
        else if (frame_start)
            live_count <= pc_peak_pkg::PEAK_RESET;
        else if (instr_step)
            live_count <= next_count;
    end

    // Running peak within the current frame
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            running_peak <= pc_peak_pkg::PEAK_RESET;
        else if (clear_on || frame_start)
            running_peak <= pc_peak_pkg::PEAK_RESET;
        else
            running_peak <= next_peak;
    end

    // Frame peak record
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            frame_peak <= pc_peak_pkg::PEAK_RESET;
        else if (clear_on)
            frame_peak <= pc_peak_pkg::PEAK_RESET;
        else if (frame_start)
            frame_peak <= next_peak;
    end

    // All-time peak record
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            alltime_peak <= pc_peak_pkg::PEAK_RESET;
        else if (clear_fall)
            alltime_peak <= pc_peak_pkg::PEAK_RESET;
        else if (frame_start && !clear_on && (next_peak > alltime_peak))
            alltime_peak <= next_peak;
    end
endmodule
`default_nettype wire

// File: rtl/pc_peak_pkg.sv
// Constants and register map of the instruction counter peak monitor
`default_nettype none
package pc_peak_pkg;
    // Register indices as printed; byte address is four times the index
    localparam logic [15:0] IDX_LIVE_UPPER   = 16'hF460;
    localparam logic [15:0] IDX_LIVE_LOWER   = 16'hF461;
    localparam logic [15:0] IDX_CLEAR_CTRL   = 16'hF462;
    localparam logic [15:0] IDX_FRAME_UPPER  = 16'hF463;
    localparam logic [15:0] IDX_FRAME_LOWER  = 16'hF464;
    localparam logic [15:0] IDX_ALLTIME_UPPER = 16'hF465;
    localparam logic [15:0] IDX_ALLTIME_LOWER = 16'hF466;
    // Field layout
    localparam int CNT_W        = 24;
    localparam int HI_LSB       = 16;
    localparam int CLEAR_BIT    = 0;
    localparam logic [15:0] CLEAR_CTRL_RESET = 16'h0000;
    localparam logic [23:0] PEAK_RESET       = 24'h000000;
    // Peak update states
    typedef enum logic [1:0] {TRACK, CLEARING} clear_state_t;
endpackage
`default_nettype wire

// File: rtl/pc_peak_regs.sv
// Read mux of the peak monitor register bank, data out of a register
`default_nettype none
module pc_peak_regs
(
    // Clock and reset
    input  wire logic        pclk,
    input  wire logic        presetn,
    // Read request
    input  wire logic        rd_en,
    input  wire logic [15:0] rd_idx,
    // Sources
    input  wire logic [23:0] live_count,
    input  wire logic [23:0] frame_peak,
    input  wire logic [23:0] alltime_peak,
    input  wire logic [15:0] clear_ctrl,
    // Read data
    output logic      [31:0] rd_data,
    output logic             rd_hit
);
    logic [31:0] sel_data;
    logic        sel_hit;

    // Index decode
    always_comb
    begin
        sel_data = 32'h00000000;
        sel_hit  = 1'b1;
        case (rd_idx)
            pc_peak_pkg::IDX_LIVE_UPPER:    sel_data = {24'h000000, live_count[23:16]};
            pc_peak_pkg::IDX_LIVE_LOWER:    sel_data = {16'h0000, live_count[15:0]};
            pc_peak_pkg::IDX_CLEAR_CTRL:    sel_data = {16'h0000, clear_ctrl};
            pc_peak_pkg::IDX_FRAME_UPPER:   sel_data = {24'h000000, frame_peak[23:16]};
            pc_peak_pkg::IDX_FRAME_LOWER:   sel_data = {16'h0000, frame_peak[15:0]};
            pc_peak_pkg::IDX_ALLTIME_UPPER: sel_data = {24'h000000, alltime_peak[23:16]};
            pc_peak_pkg::IDX_ALLTIME_LOWER: sel_data = {16'h0000, alltime_peak[15:0]};
            default:                        sel_hit  = 1'b0;
        endcase
    end

    // Registered read data
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            rd_data <= 32'h00000000;
            rd_hit  <= 1'b0;
        end
        else if (rd_en)
        begin
            rd_data <= sel_data;
            rd_hit  <= sel_hit;
        end
    end
endmodule
`default_nettype wire

// File: tb/pc_peak_asserts.sv
// Assertions on the ports of the peak monitor
`default_nettype none
module pc_peak_asserts
(
    // Clock, reset, APB
    input wire logic        pclk,
    input wire logic        presetn,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [31:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0]  pstrb,
    input wire logic [31:0] prdata,
    input wire logic        pready,
    input wire logic        pslverr,
    // Sequencer and status
    input wire logic        instr_step,
    input wire logic        frame_start,
    input wire logic [23:0] live_count
);
    timeunit 1ns;
    timeprecision 1ps;
    // ====
    // Clear bit shadow
    localparam logic [31:0] A_CLR = 32'(pc_peak_pkg::IDX_CLEAR_CTRL) << 2;
    logic acc;
    logic map;
    logic clr;
    assign acc = psel && penable;
    assign map = paddr >= 32'h0003D180 && paddr <= 32'h0003D198 && paddr[1:0] == 2'h0;
    always_ff @(posedge pclk or negedge presetn)
        if (!presetn)
            clr <= 1'b0;
        else if (acc && pready && pwrite && paddr == A_CLR)
            clr <= pstrb[0] ? pwdata[0] : clr;
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    chk_clear_hold: assert property (clr |=> live_count == 24'h000000) else $error("count moved");
    chk_step_adv: assert property (!clr && instr_step && !frame_start
        |=> live_count == $past(live_count) + 24'h000001) else $error("no advance");
    chk_idle_hold: assert property (!clr && !instr_step && !frame_start
        |=> $stable(live_count)) else $error("count drift");
    chk_frame_zero: assert property (frame_start && !instr_step |=> live_count == 24'h000000)
        else $error("no restart");
    chk_zero_wait: assert property (acc |-> pready) else $error("wait state");
    chk_idle_quiet: assert property (!psel |-> !pready && !pslverr && prdata == 32'h0) else $error("idle bus");
    chk_bad_addr: assert property (acc && !map |-> pslverr) else $error("unmapped ok");
    chk_ro_write: assert property (acc && pwrite && map && paddr != A_CLR |-> pslverr) else $error("ro write");
    chk_good_ok: assert property (acc && map && (!pwrite || paddr == A_CLR) |-> !pslverr) else $error("bad err");
    cover property (acc && pwrite && paddr == A_CLR && pwdata[0]);
    cover property (frame_start && live_count != 24'h0);
    cover property (acc && pslverr);
endmodule
bind pc_peak_monitor pc_peak_asserts i_pc_peak_asserts (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .instr_step(instr_step), .frame_start(frame_start),
    .live_count(live_count));
`default_nettype wire

// File: tb/pc_peak_monitor_bench.sv
// Self-checking bench of the peak monitor
`default_nettype none
module pc_peak_monitor_bench;
    timeunit 1ns;
    timeprecision 1ps;
    // ====
    // Signals and model
    localparam logic [31:0] A_LIV = 32'(pc_peak_pkg::IDX_LIVE_UPPER) << 2;
    localparam logic [31:0] A_CLR = 32'(pc_peak_pkg::IDX_CLEAR_CTRL) << 2;
    localparam logic [31:0] A_FRM = 32'(pc_peak_pkg::IDX_FRAME_UPPER) << 2;
    localparam logic [31:0] A_ALL = 32'(pc_peak_pkg::IDX_ALLTIME_UPPER) << 2;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, instr_step, frame_start, err, b;
    logic [31:0] paddr, pwdata, prdata, rd;
    logic [3:0]  pstrb;
    logic [23:0] live_count, cnt, fp, ap;
    int          error_cnt, check_count, seed, n;
    pc_peak_monitor i_pc_peak_monitor (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .instr_step(instr_step), .frame_start(frame_start), .live_count(live_count));
    initial
    begin
        pclk = 0;
        forever #4 pclk = ~pclk;
    end
    // Verdict and end of run
    task automatic end_sim();
        $display("errors %0d checks %0d", error_cnt, check_count);
        if (error_cnt == 0 && check_count > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    task automatic cmp(input string nm, input logic [31:0] e, input logic [31:0] g);
        check_count++;
        if (g !== e)
        begin
            error_cnt++;
            $display("CHECK FAILED %s exp %h got %h", nm, e, g);
        end
    endtask
    // One APB transfer; waits for pready
    task automatic apb(input logic w, input logic [31:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1;
        @(posedge pclk);
        while (pready !== 1'b1)
            @(posedge pclk);
        rd = prdata;
        err = pslverr;
        psel <= 0;
        penable <= 0;
    endtask
    task automatic rd24(input logic [31:0] a, input logic [23:0] e);
        apb(0, a, 0);
        cmp("upper", {24'h0, e[23:16]}, rd);
        apb(0, a + 4, 0);
        cmp("lower", {16'h0, e[15:0]}, rd);
    endtask
    // Random steps, then a boundary pulse
    task automatic frame(input int len);
        repeat (len)
        begin
            @(posedge pclk);
            b = 1'($random(seed));
            instr_step <= b;
            cnt = cnt + 24'(b);
        end
        @(posedge pclk);
        instr_step <= 0;
        @(posedge pclk);
        cmp("live", 32'(cnt), 32'(live_count));
        rd24(A_LIV, cnt);
        frame_start <= 1;
        @(posedge pclk);
        frame_start <= 0;
        fp = cnt;
        ap = fp > ap ? fp : ap;
        cnt = 0;
    endtask
    initial
    begin
        {psel, penable, pwrite, paddr, pwdata, instr_step, frame_start, presetn, cnt, ap} = '0;
        pstrb = 4'hF;
        seed = 32'h203b;
        repeat (16) @(posedge pclk);
        presetn <= 1;
        apb(0, A_CLR, 0);
        cmp("clear", 32'h0, rd);
        rd24(A_FRM, 24'h0);
        rd24(A_ALL, 24'h0);
        for (n = 0; n < 6; n++)
        begin
            frame(n == 3 ? 0 : 20 + ($random(seed) & 255));
            rd24(A_FRM, fp);
            rd24(A_ALL, ap);
        end
        frame(30);
        apb(1, A_CLR, 32'h0000A5A5);
        instr_step <= 1;
        repeat (10) @(posedge pclk);
        cmp("held", 32'h0, 32'(live_count));
        apb(0, A_CLR, 0);
        cmp("clear", 32'h0000A5A5, rd);
        rd24(A_FRM, 24'h0);
        instr_step <= 0;
        apb(1, A_CLR, 0);
        rd24(A_ALL, 24'h0);
        ap = 0;
        frame(25);
        rd24(A_ALL, fp);
        pstrb <= 4'h2;
        apb(1, A_CLR, 32'h00005678);
        pstrb <= 4'h1;
        apb(1, A_CLR, 32'h00001234);
        apb(0, A_CLR, 0);
        cmp("strobe", 32'h00005634, rd);
        pstrb <= 4'hF;
        apb(1, A_FRM, 32'hFF);
        cmp("ro", 32'h1, 32'(err));
        apb(0, 32'h0003D19C, 0);
        cmp("unmapped", 32'h1, 32'(err));
        end_sim();
    end
    initial
    begin
        repeat (20000) @(posedge pclk);
        error_cnt++;
        end_sim();
    end
endmodule
`default_nettype wire
